// ### include/seq_host_pkg.sv
// Constants and types for the metering reset and start-up host controller
package seq_host_pkg;

   // Timing at 20 MHz
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_HOLD_NS = 10000;
   localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SS_HALF_NS = 100;
   localparam int SS_HALF_CYCLES = (SS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] SS_PULSES = 2'h3;

   // Own APB register offsets
   localparam logic [7:0] APB_CTRL = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_GAIN_A = 8'h08;
   localparam logic [7:0] APB_GAIN_B = 8'h0C;
   localparam logic [7:0] APB_GAIN_C = 8'h10;
   localparam logic [7:0] APB_GAIN_N = 8'h14;
   localparam logic [7:0] APB_PULSE_OUTPUT_MODE = 8'h18;
   localparam logic [7:0] APB_LAST_READ = 8'h1C;

   // Control register fields
   localparam int CTRL_INIT = 0;
   localparam int CTRL_HW_RESET = 1;
   localparam int CTRL_SW_RESET = 2;
   localparam int CTRL_FE_RESET = 3;
   localparam int CTRL_LP_ENTER = 4;
   localparam int CTRL_LP_EXIT = 5;
   localparam int CTRL_USE_SPI = 8;

   // Device register map
   localparam logic [15:0] DEV_GAIN_A = 16'h4380;
   localparam logic [15:0] DEV_GAIN_B = 16'h4383;
   localparam logic [15:0] DEV_GAIN_C = 16'h4386;
   localparam logic [15:0] DEV_GAIN_N = 16'h4389;
   localparam logic [15:0] DEV_RUN = 16'hE228;
   localparam logic [15:0] DEV_STATUS_FIRST = 16'hE502;
   localparam logic [15:0] DEV_STATUS_SECOND = 16'hE503;
   localparam logic [15:0] DEV_PULSE_MODE = 16'hE610;
   localparam logic [15:0] DEV_MAIN_CONFIG = 16'hE618;
   localparam logic [15:0] DEV_FE_CONFIG = 16'hE708;
   localparam logic [15:0] DEV_PROTECT_CTRL = 16'hE7E3;
   localparam logic [15:0] DEV_PROTECT_KEY = 16'hE7FE;
   localparam logic [15:0] DEV_PORT_LOCK = 16'hEA00;

   // Device field positions and values
   localparam int RESET_DONE_BIT = 15;
   localparam int FE_RESET_BIT = 7;
   localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
   localparam logic [31:0] RUN_START = 32'h00000001;
   localparam logic [31:0] LOCK_I2C = 32'h00000001;
   localparam logic [31:0] LOCK_SPI = 32'h00000000;
   localparam logic [31:0] SW_RESET_VAL = 32'h00000080;
   localparam logic [31:0] FE_RESET_VAL = 32'h00000080;
   localparam logic [31:0] LP_ENTER_VAL = 32'h000000C0;
   localparam logic [31:0] LP_EXIT_VAL = 32'h00000000;
   localparam logic [31:0] PROTECT_KEY_VAL = 32'h000000AD;
   localparam logic [31:0] PROTECT_ON_VAL = 32'h00000080;
   localparam logic [15:0] PULSE_DIS_MASK = 16'h0E00;
   localparam logic [15:0] PULSE_OUTPUT_MODE_RESET = 16'h0000;

   // Sequence entry points
   localparam logic [4:0] SEQ_HW_RESET = 5'h00;
   localparam logic [4:0] SEQ_INIT = 5'h01;
   localparam logic [4:0] SEQ_SW_RESET = 5'h12;
   localparam logic [4:0] SEQ_FE_RESET = 5'h14;
   localparam logic [4:0] SEQ_LP_ENTER = 5'h17;
   localparam logic [4:0] SEQ_LP_EXIT = 5'h19;

   typedef enum logic [2:0] {K_HOLD, K_WIRQ, K_SS, K_WR, K_RD, K_POLL, K_GOTO, K_DONE} op_kind_type;

   typedef struct packed {
      op_kind_type kind;
      logic [15:0] addr;
      logic [31:0] data;
   } op_type;

   typedef struct packed {
      logic irq_s1;
      logic irq_s2;
      logic irq_s3;
      logic irq_low;
      logic busy;
      logic done;
      logic reset_done_flag_seen;
      logic locked;
      logic use_spi;
      logic [4:0] step;
      logic [7:0] cnt;
      logic [1:0] ss_falls;
      logic [3:0][31:0] gain;
      logic [15:0] pulse_output_mode;
      logic [31:0] last_rd;
      logic dev_valid;
      logic dev_write;
      logic [15:0] dev_addr;
      logic [31:0] dev_wdata;
      logic hw_reset_b;
      logic ss_out;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ctl_state_type;

endpackage : seq_host_pkg

// ### rtl/seq_host.sv
// Host controller that resets, starts and initialises the metering chipset
// Function
// - Hold hardware reset low at least 10 us
// - Write one to reset-done flag to clear
// - Select SPI by three slave-select falling edges
// - Lock port: I2C writes bit0, SPI any
// - Poll front-end config until bit 7 clears
// - Wait for interrupt low before initialising
// - Write 0x0001 to run register starts DSP
// - Write last RAM register three times
// - Protect: key 0xAD, then 0x80
// - Clear all status flags writing all ones
module seq_host
   import seq_host_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Chipset pins
   output logic device_reset_b,
   output logic slave_select_highspeed_ack_pin,
   input wire logic interrupt_one_output,
   // Device register port
   output logic dev_valid,
   output logic dev_write,
   output logic [15:0] dev_addr,
   output logic [31:0] dev_wdata,
   input wire logic dev_ready,
   input wire logic [31:0] dev_rdata
);

   ctl_state_type s;
   ctl_state_type next_s;
   op_type op;

   ////////////////////////////////////////////////////////////////////////////
   // Sequence table

   function automatic op_type step_op(input logic [4:0] idx, input logic [3:0][31:0] g,
                                      input logic [15:0] cf, input logic spi);
      op_type o;
      o = '{K_DONE, 16'h0000, 32'h00000000};
      case (idx)
         5'h00: o = '{K_HOLD, 16'h0000, 32'h00000000};
         5'h01: o = '{K_WIRQ, 16'h0000, 32'h00000000};
         5'h02: o = '{K_SS, 16'h0000, 32'h00000000};
         5'h03: o = '{K_RD, DEV_STATUS_SECOND, 32'h00000000};
         5'h04: o = '{K_WR, DEV_STATUS_SECOND, ALL_ONES};
         5'h05: o = '{K_WR, DEV_STATUS_FIRST, ALL_ONES};
         5'h06: o = '{K_WR, DEV_PORT_LOCK, spi ? LOCK_SPI : LOCK_I2C};
         5'h07: o = '{K_WR, DEV_RUN, RUN_START};
         5'h08: o = '{K_WR, DEV_GAIN_A, g[0]};
         5'h09: o = '{K_WR, DEV_GAIN_B, g[1]};
         5'h0A: o = '{K_WR, DEV_GAIN_C, g[2]};
         5'h0B: o = '{K_WR, DEV_GAIN_N, g[3]};
         5'h0C: o = '{K_WR, DEV_GAIN_N, g[3]};
         5'h0D: o = '{K_WR, DEV_GAIN_N, g[3]};
         5'h0E: o = '{K_WR, DEV_PROTECT_KEY, PROTECT_KEY_VAL};
         5'h0F: o = '{K_WR, DEV_PROTECT_CTRL, PROTECT_ON_VAL};
         5'h10: o = '{K_WR, DEV_PULSE_MODE, {16'h0000, cf & ~PULSE_DIS_MASK}};
         5'h11: o = '{K_DONE, 16'h0000, 32'h00000000};
         5'h12: o = '{K_WR, DEV_MAIN_CONFIG, SW_RESET_VAL};
         5'h13: o = '{K_GOTO, 16'h0000, {27'h0, SEQ_INIT}};
         5'h14: o = '{K_WR, DEV_FE_CONFIG, FE_RESET_VAL};
         5'h15: o = '{K_POLL, DEV_FE_CONFIG, 32'h00000000};
         5'h17: o = '{K_WR, DEV_FE_CONFIG, LP_ENTER_VAL};
         5'h19: o = '{K_WR, DEV_FE_CONFIG, LP_EXIT_VAL};
         default: o = '{K_DONE, 16'h0000, 32'h00000000};
      endcase
      return o;
   endfunction : step_op

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_s = s;
      op = step_op(s.step, s.gain, s.pulse_output_mode, s.use_spi);
      // Three-stage pin synchroniser; accept once the later stages agree
      next_s.irq_s1 = interrupt_one_output;
      next_s.irq_s2 = s.irq_s1;
      next_s.irq_s3 = s.irq_s2;
      if (s.irq_s2 == s.irq_s3) begin
         next_s.irq_low = ~s.irq_s3;
      end

      // APB: one wait state, answer registered
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      if (psel && penable && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.prdata = 32'h00000000;
         if (paddr == APB_CTRL) begin
            next_s.prdata[CTRL_USE_SPI] = s.use_spi;
         end else if (paddr == APB_STATUS) begin
            next_s.prdata = {19'h0, s.step, 3'h0, s.locked, s.reset_done_flag_seen, s.irq_low,
                             s.done, s.busy};
         end else if (paddr == APB_GAIN_A) begin
            next_s.prdata = s.gain[0];
         end else if (paddr == APB_GAIN_B) begin
            next_s.prdata = s.gain[1];
         end else if (paddr == APB_GAIN_C) begin
            next_s.prdata = s.gain[2];
         end else if (paddr == APB_GAIN_N) begin
            next_s.prdata = s.gain[3];
         end else if (paddr == APB_PULSE_OUTPUT_MODE) begin
            next_s.prdata = {16'h0000, s.pulse_output_mode};
         end else if (paddr == APB_LAST_READ) begin
            next_s.prdata = s.last_rd;
         end else begin
            next_s.pslverr = 1'b1;
         end
      end
      if (psel && penable && pwrite && s.pready) begin
         if (paddr == APB_CTRL) begin
            // Commands while busy are dropped; hardware reset has priority
            if (!s.busy && (pwdata[5:0] != 6'h00)) begin
               next_s.busy = 1'b1;
               next_s.done = 1'b0;
               next_s.cnt = 8'h00;
               next_s.use_spi = pwdata[CTRL_USE_SPI];
               if (pwdata[CTRL_HW_RESET]) begin
                  next_s.step = SEQ_HW_RESET;
               end else if (pwdata[CTRL_SW_RESET]) begin
                  next_s.step = SEQ_SW_RESET;
               end else if (pwdata[CTRL_FE_RESET]) begin
                  next_s.step = SEQ_FE_RESET;
               end else if (pwdata[CTRL_LP_ENTER]) begin
                  next_s.step = SEQ_LP_ENTER;
               end else if (pwdata[CTRL_LP_EXIT]) begin
                  next_s.step = SEQ_LP_EXIT;
               end else begin
                  next_s.step = SEQ_INIT;
               end
            end
         end else if (paddr == APB_GAIN_A) begin
            next_s.gain[0] = pwdata;
         end else if (paddr == APB_GAIN_B) begin
            next_s.gain[1] = pwdata;
         end else if (paddr == APB_GAIN_C) begin
            next_s.gain[2] = pwdata;
         end else if (paddr == APB_GAIN_N) begin
            next_s.gain[3] = pwdata;
         end else if (paddr == APB_PULSE_OUTPUT_MODE) begin
            next_s.pulse_output_mode = pwdata[15:0];
         end
      end

      // Sequencer
      if (s.busy) begin
         case (op.kind)
            K_HOLD: begin
               next_s.hw_reset_b = 1'b0;
               next_s.cnt = s.cnt + 8'h01;
               if (s.cnt == 8'(RESET_HOLD_CYCLES)) begin
                  next_s.hw_reset_b = 1'b1;
                  next_s.cnt = 8'h00;
                  next_s.step = s.step + 5'h01;
                  // Device drops its port lock and flags on hardware reset
                  next_s.locked = 1'b0;
                  next_s.ss_falls = 2'h0;
                  next_s.reset_done_flag_seen = 1'b0;
               end
            end
            K_WIRQ: begin
               if (s.irq_low) begin
                  next_s.step = s.step + 5'h01;
               end
            end
            K_SS: begin
               if (!s.use_spi || s.locked) begin
                  next_s.step = s.step + 5'h01;
               end else begin
                  next_s.cnt = s.cnt + 8'h01;
                  if (s.cnt == 8'(SS_HALF_CYCLES - 1)) begin
                     next_s.cnt = 8'h00;
                     if (s.ss_out) begin
                        next_s.ss_out = 1'b0;
                        next_s.ss_falls = s.ss_falls + 2'h1;
                     end else begin
                        next_s.ss_out = 1'b1;
                        if (s.ss_falls == SS_PULSES) begin
                           next_s.step = s.step + 5'h01;
                        end
                     end
                  end
               end
            end
            K_WR, K_RD, K_POLL: begin
               if (!s.dev_valid) begin
                  next_s.dev_valid = 1'b1;
                  next_s.dev_write = (op.kind == K_WR);
                  next_s.dev_addr = op.addr;
                  next_s.dev_wdata = op.data;
               end else if (dev_ready) begin
                  next_s.dev_valid = 1'b0;
                  next_s.step = s.step + 5'h01;
                  if (!s.dev_write) begin
                     next_s.last_rd = dev_rdata;
                  end
                  if (op.kind == K_RD && s.dev_addr == DEV_STATUS_SECOND) begin
                     next_s.reset_done_flag_seen = dev_rdata[RESET_DONE_BIT];
                  end
                  if (op.kind == K_POLL && dev_rdata[FE_RESET_BIT]) begin
                     next_s.step = s.step;
                  end
                  if (s.dev_write && s.dev_addr == DEV_PORT_LOCK) begin
                     next_s.locked = 1'b1;
                  end
               end
            end
            K_GOTO: begin
               next_s.step = op.data[4:0];
            end
            default: begin
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
            end
         endcase
      end

      if (!rst_b) begin
         next_s = '0;
         next_s.hw_reset_b = 1'b1;
         next_s.ss_out = 1'b1;
         next_s.pulse_output_mode = PULSE_OUTPUT_MODE_RESET;
         next_s.step = SEQ_INIT;
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign device_reset_b = s.hw_reset_b;
   assign slave_select_highspeed_ack_pin = s.ss_out;
   assign dev_valid = s.dev_valid;
   assign dev_write = s.dev_write;
   assign dev_addr = s.dev_addr;
   assign dev_wdata = s.dev_wdata;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [7:0] low_cnt;
   logic [1:0] rep_cnt;
   logic [15:0] prev_addr;
   logic key_armed;
   logic irq_seen;
   logic [1:0] falls_seen;
   logic wr_done;

   assign wr_done = s.dev_valid && dev_ready && s.dev_write;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         low_cnt <= 8'h00;
         rep_cnt <= 2'h0;
         prev_addr <= 16'h0000;
         key_armed <= 1'b0;
         irq_seen <= 1'b0;
         falls_seen <= 2'h0;
      end else begin
         low_cnt <= s.hw_reset_b ? 8'h00 : ((low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01);
         if (!s.hw_reset_b) begin
            irq_seen <= 1'b0;
            falls_seen <= 2'h0;
         end else begin
            if (s.irq_low) begin
               irq_seen <= 1'b1;
            end
            if ($fell(s.ss_out) && falls_seen != 2'h3) begin
               falls_seen <= falls_seen + 2'h1;
            end
         end
         if (wr_done) begin
            prev_addr <= s.dev_addr;
            rep_cnt <= (s.dev_addr == prev_addr && rep_cnt != 2'h3) ? rep_cnt + 2'h1 : 2'h1;
            key_armed <= (s.dev_addr == DEV_PROTECT_KEY) && (s.dev_wdata == PROTECT_KEY_VAL);
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence fe_reset_written;
      // Low-power entry also sets bit 7 but is never polled
      wr_done && s.dev_addr == DEV_FE_CONFIG && s.dev_wdata[7:0] == FE_RESET_VAL[7:0];
   endsequence

   sequence fe_reset_polled;
      ##[1:3] s.dev_valid && !s.dev_write && s.dev_addr == DEV_FE_CONFIG;
   endsequence

   AST_RESET_HOLD: assert property ($rose(s.hw_reset_b) |-> low_cnt >= RESET_HOLD_CYCLES - 1)
      else $error("device reset released too early");
   AST_RUN_VALUE: assert property (s.dev_valid && s.dev_write && s.dev_addr == DEV_RUN
                                   |-> s.dev_wdata == RUN_START)
      else $error("run register written with wrong value");
   AST_KEY_FIRST: assert property (s.dev_valid && s.dev_write && s.dev_addr == DEV_PROTECT_CTRL
                                   |-> key_armed && s.dev_wdata == PROTECT_ON_VAL)
      else $error("protection enabled without key");
   AST_LAST_THRICE: assert property (s.dev_valid && s.dev_addr == DEV_PROTECT_KEY
                                     |-> prev_addr == DEV_GAIN_N && rep_cnt == 2'h3)
      else $error("last RAM register not written three times");
   AST_W1C_DONE: assert property (s.dev_valid && s.dev_write && s.dev_addr == DEV_STATUS_SECOND
                                  |-> s.dev_wdata == ALL_ONES)
      else $error("reset-done flag not cleared by a one");
   AST_CLEAR_FIRST: assert property (s.dev_valid && s.dev_write && s.dev_addr == DEV_STATUS_FIRST
                                     |-> s.dev_wdata == ALL_ONES)
      else $error("first status not cleared with all ones");
   AST_WAIT_IRQ: assert property (s.dev_valid && s.dev_addr == DEV_STATUS_SECOND
                                  |-> irq_seen && s.irq_low)
      else $error("initialisation before interrupt low");
   AST_SS_COUNT: assert property (s.dev_valid && s.dev_write && s.dev_addr == DEV_PORT_LOCK
                                  |-> falls_seen == (s.use_spi ? 2'h3 : 2'h0))
      else $error("wrong number of slave-select edges");
   AST_LOCK_I2C: assert property (s.dev_valid && s.dev_addr == DEV_PORT_LOCK && !s.use_spi
                                  |-> s.dev_wdata[0])
      else $error("I2C lock bit not set");
   AST_FE_POLL: assert property (fe_reset_written |-> fe_reset_polled)
      else $error("front-end reset not polled");
   AST_PULSE_ENABLE: assert property (s.dev_valid && s.dev_addr == DEV_PULSE_MODE
                                      |-> (s.dev_wdata[15:0] & PULSE_DIS_MASK) == 16'h0000)
      else $error("pulse outputs left disabled");

endmodule : seq_host

// ### testbench/seq_device_model.sv
// Behavioural model of the metering chipset as seen from its host port
module seq_device_model
   import seq_host_pkg::*;
#(
   parameter int PU_CYCLES = 30,
   parameter int BURST_CYCLES = 16,
   parameter int SLOW_WAIT = 3
)
(
   // Clock and power-on
   input wire logic clk,
   input wire logic rst_b,
   // Chipset pins
   input wire logic device_reset_b,
   input wire logic slave_select_highspeed_ack_pin,
   output logic interrupt_one_output,
   // Register port
   input wire logic dev_valid,
   input wire logic dev_write,
   input wire logic [15:0] dev_addr,
   input wire logic [31:0] dev_wdata,
   output logic dev_ready,
   output logic [31:0] dev_rdata
);
   logic reset_done_flag, spi, ss_q, key_ok, protect, slow;
   logic [1:0] lock, ss_falls;
   logic [15:0] run, main_cfg, pulse_output_mode;
   logic [7:0] fe_cfg;
   logic [3:0][31:0] gain;
   logic [31:0] status_first;
   int busy, fe_busy, wait_n, gain_n_wr, fe_polls, ss_total;

   // Unmaskable: interrupt follows the reset-done flag alone
   assign interrupt_one_output = ~reset_done_flag;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      dev_ready <= 1'b0;
      // Idle read data keeps moving so a stale sample is never mistaken for data
      dev_rdata <= ~dev_rdata;
      ss_q <= slave_select_highspeed_ack_pin;
      if (!rst_b || !device_reset_b) begin
         reset_done_flag <= 1'b0;
         {spi, lock, ss_falls, key_ok, protect, slow} <= '0;
         {run, main_cfg, pulse_output_mode, fe_cfg, gain} <= '0;
         status_first <= 32'h00000F0F;
         busy <= PU_CYCLES;
         {fe_busy, wait_n} <= '0;
         // Event counters only clear at power-on so the bench can sum them
         if (!rst_b) begin
            {ss_total, gain_n_wr, fe_polls, dev_rdata} <= '0;
         end
      end else begin
         if (ss_q && !slave_select_highspeed_ack_pin) begin
            ss_total <= ss_total + 1;
            if (lock == 2'h0 && !spi) begin
               ss_falls <= ss_falls + 2'h1;
               spi <= (ss_falls == 2'h2);
            end
         end
         if (busy > 1) busy <= busy - 1;
         else if (busy == 1) begin
            busy <= 0;
            reset_done_flag <= 1'b1;
            main_cfg[7] <= 1'b0;
         end
         if (fe_busy > 1) fe_busy <= fe_busy - 1;
         else if (fe_busy == 1) begin
            fe_busy <= 0;
            fe_cfg[7] <= 1'b0;
         end
         if (dev_valid && !dev_ready) begin
            if (wait_n < (slow ? SLOW_WAIT : 0)) wait_n <= wait_n + 1;
            else begin
               dev_ready <= 1'b1;
               wait_n <= 0;
               slow <= ~slow;
               if (dev_write) begin
                  case (dev_addr)
                     DEV_STATUS_SECOND: if (dev_wdata[15]) reset_done_flag <= 1'b0;
                     DEV_STATUS_FIRST: status_first <= status_first & ~dev_wdata;
                     DEV_PORT_LOCK: if (lock == 2'h0) lock <= spi ? 2'h2 : {1'b0, dev_wdata[0]};
                     DEV_RUN: run <= dev_wdata[15:0];
                     DEV_MAIN_CONFIG: begin
                        main_cfg <= dev_wdata[15:0];
                        if (dev_wdata[7]) begin
                           // Port choice and lock survive a full software reset
                           {run, pulse_output_mode, fe_cfg, gain, key_ok, protect} <= '0;
                           reset_done_flag <= 1'b0;
                           busy <= BURST_CYCLES;
                        end
                     end
                     DEV_FE_CONFIG: begin
                        fe_cfg <= dev_wdata[7:0];
                        if (dev_wdata[7:6] == 2'h2) fe_busy <= BURST_CYCLES;
                     end
                     DEV_PROTECT_KEY: key_ok <= (dev_wdata[7:0] == 8'hAD);
                     DEV_PROTECT_CTRL: if (key_ok && dev_wdata[7:0] == 8'h80) protect <= 1'b1;
                     DEV_PULSE_MODE: pulse_output_mode <= dev_wdata[15:0];
                     DEV_GAIN_A: gain[0] <= dev_wdata;
                     DEV_GAIN_B: gain[1] <= dev_wdata;
                     DEV_GAIN_C: gain[2] <= dev_wdata;
                     DEV_GAIN_N: begin
                        gain[3] <= dev_wdata;
                        gain_n_wr <= gain_n_wr + 1;
                     end
                     default: ;
                  endcase
               end else begin
                  case (dev_addr)
                     DEV_STATUS_SECOND: dev_rdata <= {16'h0000, reset_done_flag, 15'h0000};
                     DEV_FE_CONFIG: begin
                        dev_rdata <= {24'h000000, fe_cfg};
                        fe_polls <= fe_polls + 1;
                     end
                     default: dev_rdata <= 32'h00000000;
                  endcase
               end
            end
         end
      end
   end

endmodule : seq_device_model

// ### testbench/seq_host_bench.sv
// Self-checking bench for the reset and start-up host controller
module seq_host_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import seq_host_pkg::*;

   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic device_reset_b, ss_pin, irq_b, dev_valid, dev_write, dev_ready;
   logic [15:0] dev_addr;
   logic [31:0] dev_wdata, dev_rdata;
   int fail_count, total_checks, cycles, lo_len;

   seq_host dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .device_reset_b(device_reset_b),
      .slave_select_highspeed_ack_pin(ss_pin), .interrupt_one_output(irq_b),
      .dev_valid(dev_valid), .dev_write(dev_write), .dev_addr(dev_addr),
      .dev_wdata(dev_wdata), .dev_ready(dev_ready), .dev_rdata(dev_rdata));

   seq_device_model dev_u (.clk(clk), .rst_b(rst_b), .device_reset_b(device_reset_b),
      .slave_select_highspeed_ack_pin(ss_pin), .interrupt_one_output(irq_b),
      .dev_valid(dev_valid), .dev_write(dev_write), .dev_addr(dev_addr),
      .dev_wdata(dev_wdata), .dev_ready(dev_ready), .dev_rdata(dev_rdata));

   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task conclude;
      if (fail_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   // One edge of slack first, so a release and a new setup never share a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cmd(input logic [31:0] v);
      apb(1'b1, APB_CTRL, v);
      do apb(1'b0, APB_STATUS, 32'h0); while (!(rd[0] === 1'b0 && rd[1] === 1'b1));
   endtask : cmd

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (device_reset_b === 1'b0) lo_len <= lo_len + 1;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end

   initial begin
      {clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      {fail_count, total_checks, cycles, lo_len} = '0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, APB_PULSE_OUTPUT_MODE, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      check({31'h0, er}, 32'h1);
      for (int i = 0; i < 4; i++) apb(1'b1, APB_GAIN_A + 8'(4 * i), 32'hA5000000 | i);
      apb(1'b0, APB_GAIN_N, 32'h0);
      check(rd, 32'hA5000003);
      apb(1'b1, APB_PULSE_OUTPUT_MODE, 32'h0000FFFF);
      // Start-up on SPI from power-on
      cmd(32'h00000101);
      check({31'h0, rd[4]}, 32'h1);
      check(32'(dev_u.ss_total), 32'h3);
      check({30'h0, dev_u.lock}, 32'h2);
      check({16'h0, dev_u.run}, RUN_START);
      check({31'h0, irq_b}, 32'h1);
      check(dev_u.status_first, 32'h0);
      check({31'h0, dev_u.protect}, 32'h1);
      check({16'h0, dev_u.pulse_output_mode}, 32'h0000F1FF);
      check(32'(dev_u.gain_n_wr), 32'h3);
      check(dev_u.gain[3], 32'hA5000003);
      // Full software reset keeps the SPI lock, so no new selection pulses
      cmd(32'h00000104);
      check(32'(dev_u.ss_total), 32'h3);
      check({16'h0, dev_u.run}, RUN_START);
      check({31'h0, irq_b}, 32'h1);
      check(32'(dev_u.gain_n_wr), 32'h6);
      cmd(32'h00000008);
      check({24'h0, dev_u.fe_cfg}, 32'h0);
      check({31'h0, dev_u.fe_polls >= 2}, 32'h1);
      cmd(32'h00000010);
      check({24'h0, dev_u.fe_cfg}, LP_ENTER_VAL);
      cmd(32'h00000020);
      check({24'h0, dev_u.fe_cfg}, LP_EXIT_VAL);
      check({16'h0, dev_u.run}, RUN_START);
      // Hardware reset to I2C; a command while busy must be ignored
      lo_len = 0;
      apb(1'b1, APB_CTRL, 32'h00000002);
      apb(1'b1, APB_CTRL, 32'h00000010);
      do apb(1'b0, APB_STATUS, 32'h0); while (!(rd[0] === 1'b0 && rd[1] === 1'b1));
      check({31'h0, lo_len >= RESET_HOLD_CYCLES}, 32'h1);
      check({31'h0, dev_u.spi}, 32'h0);
      check({30'h0, dev_u.lock}, 32'h1);
      check({24'h0, dev_u.fe_cfg}, 32'h0);
      check({16'h0, dev_u.run}, RUN_START);
      check({31'h0, irq_b}, 32'h1);
      conclude();
   end
endmodule : seq_host_bench
